// file: design/dwu_ctrl.sv
/*
  dwu_ctrl: analog output update control for two output converters.
  Holds channel registers, a two-entry input buffer, the waveform fifo,
  trigger selection, the fifo read engine and the status flags.
  Assumes trigger and counter pins are asynchronous to sys_clk; the
  host drives strobes and data synchronously for one cycle each.
*/
`timescale 1ns/1ps

// Functional notes
// - channel registers load their own 16-bit converter
// - update immediately, on trigger pulse, or strobe
// - trigger from connector or selected counter output
// - update method chosen by mode input bits
// - waveform trigger updates, requests data; 2048 fifo
// - request when not full or below half
// - single update pops one, alternates channels
// - dual update pops up to two entries
// - dual with one channel reads once
// - cyclic updating follows the timing signal
// - fifo resident buffer replays from its start
// - stop bit halts at next buffer end
// - retransmit pulse routed to counter 3 source
// - cycle counter end halts waveform fifo reads only
// - clear drops timer request and complete flags
module dwu_ctrl #(
  parameter int DEPTH = dwu_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // channel registers and update strobe
  input  wire logic [dwu_pkg::DATA_W-1:0] ch_wdata,
  input  wire logic                       ch0_write,
  input  wire logic                       ch1_write,
  input  wire logic                       update_strobe,
  input  wire logic                       clear_strobe,
  // waveform data stream
  input  wire logic [dwu_pkg::DATA_W-1:0] in_data,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  // configuration
  input  wire dwu_pkg::dwu_mode_e         update_mode,
  input  wire logic                       waveform_enable,
  input  wire logic                       cyclic_enable,
  input  wire logic [1:0]                 channel_enable,
  input  wire logic                       dual_update_enable,
  input  wire logic                       request_half_full,
  input  wire logic                       stop_at_buffer_end,
  input  wire logic                       retransmit_to_counter_source,
  input  wire logic                       trigger_receive_select,
  input  wire logic [1:0]                 counter_select,
  // flag clears
  input  wire logic                       timer_request_clear,
  input  wire logic                       output_complete_clear,
  // pins
  input  wire logic                       external_update_trigger_n,
  input  wire logic [3:0]                 counter_out_n,
  input  wire logic                       cycle_count_end,
  // outputs
  output logic [dwu_pkg::DATA_W-1:0]      analog_output_zero_pin,
  output logic [dwu_pkg::DATA_W-1:0]      analog_output_one_pin,
  output logic                            counter3_source,
  output logic                            data_request,
  output logic                            timer_request_flag,
  output logic                            output_complete_flag,
  output logic                            buffer_stopped,
  output logic [$clog2(DEPTH):0]          fifo_level
);
  import dwu_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] HALF_CNT = (AW+1)'(DEPTH / 2);

  // refuse depths the pointer arithmetic cannot serve
  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("dwu_ctrl: DEPTH must be a power of two, at least 4");
  end

  logic [SYNC_N-1:0]  pin_raw;
  logic [SYNC_N-1:0]  sy1;
  logic [SYNC_N-1:0]  sy2;
  logic [SYNC_N-1:0]  sy3;
  logic [SYNC_N-1:0]  pin_f;
  logic               trig_level;
  logic               trig_prev;
  logic               trig_evt;
  logic               upd_evt;
  logic               run_ok;
  logic [DATA_W-1:0]  ch_reg0;
  logic [DATA_W-1:0]  ch_reg1;
  logic [DATA_W-1:0]  sk_data [SKID_DEPTH];
  logic [1:0]         sk_cnt;
  logic               sk_head;
  logic [1:0]         next_sk_cnt;
  logic               sk_in;
  logic               sk_out;
  logic [DATA_W-1:0]  mem [DEPTH];
  logic [AW-1:0]      wr_ptr;
  logic [AW-1:0]      rd_ptr;
  logic [AW:0]        count;
  logic [AW:0]        pos;
  logic [AW-1:0]      rd_idx;
  logic               both;
  logic               dual_go;
  logic               rd_take;
  logic               eob;
  logic               tgt;
  logic               ch_turn;
  dwu_state_e         state;

  // pins pass three flops; a level counts once stages two and three agree
  assign pin_raw = {cycle_count_end, counter_out_n, external_update_trigger_n};
  for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        sy1[i]   <= (i == SY_END) ? 1'b0 : 1'b1;
        sy2[i]   <= (i == SY_END) ? 1'b0 : 1'b1;
        sy3[i]   <= (i == SY_END) ? 1'b0 : 1'b1;
        pin_f[i] <= (i == SY_END) ? 1'b0 : 1'b1;
      end else begin
        sy1[i] <= pin_raw[i];
        sy2[i] <= sy1[i];
        sy3[i] <= sy2[i];
        if (sy2[i] == sy3[i]) begin
          pin_f[i] <= sy3[i];
        end
      end
    end
  end

  // trigger source and falling edge; a select change may look like an edge
  assign trig_level = trigger_receive_select ?
                      pin_f[SY_CNT + int'(counter_select)] : pin_f[SY_EXT];
  assign trig_evt   = trig_prev & ~trig_level;
  assign upd_evt    = (update_mode == UPD_TIMER  && trig_evt) ||
                      (update_mode == UPD_STROBE && update_strobe);
  assign run_ok     = ~pin_f[SY_END] & ~buffer_stopped;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev <= 1'b1;
    end else begin
      trig_prev <= trig_level;
    end
  end

  // channel data registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ch_reg0 <= CODE_RST;
      ch_reg1 <= CODE_RST;
    end else begin
      if (ch0_write) ch_reg0 <= ch_wdata;
      if (ch1_write) ch_reg1 <= ch_wdata;
    end
  end

  // two-entry input buffer in front of the fifo
  assign sk_in  = in_valid & in_ready;
  assign sk_out = (sk_cnt != 2'd0) && (count != FULL_CNT);
  always_comb begin
    next_sk_cnt = sk_cnt + 2'(sk_in) - 2'(sk_out);
    if (clear_strobe) next_sk_cnt = 2'd0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sk_cnt   <= 2'd0;
      sk_head  <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      sk_cnt   <= next_sk_cnt;
      in_ready <= next_sk_cnt != 2'(SKID_DEPTH);
      if (clear_strobe) begin
        sk_head <= 1'b0;
      end else if (sk_out) begin
        sk_head <= ~sk_head;
      end
    end
  end

  // new word lands behind the held one, even while the head leaves
  always_ff @(posedge sys_clk) begin
    if (sk_in) begin
      sk_data[sk_head ^ (sk_cnt != 2'd0)] <= in_data;
    end
  end

  // fifo storage
  always_ff @(posedge sys_clk) begin
    if (sk_out) mem[wr_ptr] <= sk_data[sk_head];
  end

  // read engine decisions
  assign both    = &channel_enable;
  assign dual_go = dual_update_enable & both;
  assign rd_idx  = cyclic_enable ? rd_ptr + pos[AW-1:0] : rd_ptr;
  assign rd_take = waveform_enable && run_ok && count != '0 &&
                   ((state == ST_IDLE && upd_evt) || state == ST_SECOND);
  assign eob     = rd_take && cyclic_enable && (pos + 1'b1 == count);
  assign tgt     = both ? ch_turn : (channel_enable[1] & ~channel_enable[0]);

  // second read only in dual mode with both channels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (clear_strobe) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:   state <= (rd_take && dual_go) ? ST_SECOND : ST_IDLE;
        ST_SECOND: state <= ST_IDLE;
        default:   state <= ST_IDLE;
      endcase
    end
  end

  // pointers, level and replay position
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count   <= '0;
      pos     <= '0;
      ch_turn <= 1'b0;
    end else if (clear_strobe) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count   <= '0;
      pos     <= '0;
      ch_turn <= 1'b0;
    end else begin
      if (sk_out) wr_ptr <= wr_ptr + 1'b1;
      if (rd_take && !cyclic_enable) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(sk_out) -
               (AW+1)'(rd_take && !cyclic_enable);
      if (eob) begin
        pos <= '0;
      end else if (rd_take && cyclic_enable) begin
        pos <= pos + 1'b1;
      end
      if (rd_take && both) ch_turn <= ~ch_turn;
    end
  end

  // stop at buffer end and retransmit pulse to the counter source
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_stopped  <= 1'b0;
      counter3_source <= 1'b0;
    end else begin
      counter3_source <= eob & retransmit_to_counter_source;
      if (eob && stop_at_buffer_end) begin
        buffer_stopped <= 1'b1;
      end else if (clear_strobe) begin
        buffer_stopped <= 1'b0;
      end
    end
  end

  // converter codes: fifo in waveform mode, registers otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_output_zero_pin <= CODE_RST;
      analog_output_one_pin  <= CODE_RST;
    end else if (waveform_enable) begin
      if (rd_take && !tgt) analog_output_zero_pin <= mem[rd_idx];
      if (rd_take && tgt)  analog_output_one_pin  <= mem[rd_idx];
    end else if (update_mode == UPD_IMMEDIATE) begin
      if (ch0_write) analog_output_zero_pin <= ch_wdata;
      if (ch1_write) analog_output_one_pin  <= ch_wdata;
    end else if (upd_evt) begin
      analog_output_zero_pin <= ch_reg0;
      analog_output_one_pin  <= ch_reg1;
    end
  end

  // status flags; a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_request_flag   <= 1'b0;
      output_complete_flag <= 1'b0;
      data_request         <= 1'b0;
      fifo_level           <= '0;
    end else begin
      if (waveform_enable && update_mode == UPD_TIMER && trig_evt) begin
        timer_request_flag <= 1'b1;
      end else if (clear_strobe || timer_request_clear) begin
        timer_request_flag <= 1'b0;
      end
      if (rd_take || (!waveform_enable && upd_evt)) begin
        output_complete_flag <= 1'b1;
      end else if (clear_strobe || output_complete_clear) begin
        output_complete_flag <= 1'b0;
      end
      data_request <= waveform_enable && (request_half_full ?
                      count < HALF_CNT : count != FULL_CNT);
      fifo_level   <= count;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_FIFO_BOUND: assert property (count <= FULL_CNT)
    else $error("fifo level above depth");
  AST_SINGLE_POP: assert property (
    state == ST_IDLE && rd_take && !dual_go && !clear_strobe
    |=> state == ST_IDLE)
    else $error("single update took a second read");
  AST_DUAL_SECOND: assert property (
    state == ST_IDLE && rd_take && dual_go && !clear_strobe
    |=> state == ST_SECOND ##1 state == ST_IDLE)
    else $error("dual update missed its second read");
  AST_ONE_CHANNEL: assert property (
    rd_take && !both |=> state == ST_IDLE &&
    ($past(channel_enable[1]) ? $stable(analog_output_zero_pin)
                              : $stable(analog_output_one_pin)))
    else $error("single channel routed wrongly");
  AST_HALT_END: assert property (
    waveform_enable && pin_f[SY_END] |-> !rd_take ##1
    $stable(analog_output_zero_pin) && $stable(analog_output_one_pin))
    else $error("read while cycle counter ended");
  AST_STOP_END: assert property (
    eob && stop_at_buffer_end |=> buffer_stopped && !rd_take)
    else $error("no stop at buffer end");
  AST_RETX: assert property (
    eob && retransmit_to_counter_source |=> counter3_source)
    else $error("retransmit pulse missing");
  AST_CLEAR: assert property (
    clear_strobe |=> count == '0 && pos == '0 && state == ST_IDLE)
    else $error("clear left fifo state");
  AST_IMMEDIATE: assert property (
    !waveform_enable && update_mode == UPD_IMMEDIATE && ch0_write
    |=> analog_output_zero_pin == $past(ch_wdata))
    else $error("immediate write not applied");
  AST_HALF_REQ: assert property (
    waveform_enable && request_half_full && count >= HALF_CNT
    |=> !data_request)
    else $error("request above half full");

  COV_DUAL: cover property (rd_take && dual_go ##1 rd_take);
  COV_WRAP: cover property (eob);
  COV_STOP: cover property (eob && stop_at_buffer_end);
  COV_FULL: cover property (count == FULL_CNT && in_valid && !in_ready);

endmodule : dwu_ctrl

// file: inc/dwu_pkg.sv
/*
  dwu_pkg: shared constants and types of the analog output update block.
  Assumes a single 20 MHz clock domain; no bus, all controls are ports.
*/
package dwu_pkg;

  // code width and waveform fifo depth after reset
  localparam int          DATA_W     = 16;
  localparam int          FIFO_DEPTH = 2048;
  localparam int          SKID_DEPTH = 2;
  localparam logic [15:0] CODE_RST   = 16'h0000;

  // positions inside the synchroniser vector
  localparam int SYNC_N = 6;
  localparam int SY_EXT = 0;  // connector trigger
  localparam int SY_CNT = 1;  // counter outputs 1, 2, 3, 5 at 1..4
  localparam int SY_END = 5;  // cycle counter terminal count

  // update method
  typedef enum logic [1:0] {
    UPD_IMMEDIATE = 2'b00,
    UPD_TIMER     = 2'b01,
    UPD_STROBE    = 2'b10
  } dwu_mode_e;

  // fifo read engine
  typedef enum logic {
    ST_IDLE   = 1'b0,
    ST_SECOND = 1'b1
  } dwu_state_e;

endpackage : dwu_pkg

// file: test/dwu_host_model.sv
/*
  dwu_host_model: host side that feeds waveform samples into the stream.
  Assumes the bench queues words in channel order and one sys_clk domain.
*/
`timescale 1ns/1ps
module dwu_host_model (
  // clock and handshake
  input  wire logic                  sys_clk,
  input  wire logic                  in_ready,
  // sample stream
  output logic [dwu_pkg::DATA_W-1:0] in_data,
  output logic                       in_valid
);
  import dwu_pkg::*;

  logic [DATA_W-1:0] q[$];
  logic [DATA_W-1:0] last = '0;
  logic [DATA_W-1:0] dat  = 16'hFFFF;
  logic              vld  = 1'b0;
  logic              slow = 1'b0;
  logic              gap  = 1'b0;

  // stream outputs follow the held word and its valid
  assign in_valid = vld;
  assign in_data  = dat;

  // queue a sample; channel 0 word always ahead of its channel 1 word
  task automatic push(input logic [DATA_W-1:0] d);
    q.push_back(d);
  endtask : push

  // word held until taken; idle data shows the inverse of the last word
  always @(posedge sys_clk) begin
    gap = slow & ~gap;
    if (vld && in_ready) begin
      last = q.pop_front();
    end
    if (!(vld && !in_ready)) begin
      if (q.size() > 0 && !gap) begin
        vld <= 1'b1;
        dat <= q[0];
      end else begin
        vld <= 1'b0;
        dat <= ~last;
      end
    end
  end
endmodule : dwu_host_model

// file: test/tb_dwu_ctrl.sv
/*
  tb_dwu_ctrl: self-checking bench of the analog output update block.
  Assumes a fifo depth of 8 and the host model on the stream port.
*/
`timescale 1ns/1ps
module tb_dwu_ctrl;
  import dwu_pkg::*;

  localparam int D = 8;
  logic              sys_clk  = 1'b0;
  logic              rst_n    = 1'b0;
  logic [DATA_W-1:0] ch_wdata = '0;
  logic [5:0]        stb      = '0;  // ch0 ch1 update clear treq done
  logic [4:0]        pin_n    = '1;  // connector, counters 1 2 3 5
  dwu_mode_e         mode     = UPD_IMMEDIATE;
  logic              wave = 1'b0, cyc = 1'b0, dual = 1'b0, half = 1'b0;
  logic              stop = 1'b0, rtx = 1'b0, rsel = 1'b0, cend = 1'b0;
  logic [1:0]        chen = 2'b11;
  logic [1:0]        csel = '0;
  logic [DATA_W-1:0] in_data, out0, out1, d, e;
  logic [DATA_W-1:0] w [10];
  logic              in_valid, in_ready, c3src, dreq, treq, done, stopped;
  logic [3:0]        level;
  integer            seed = 32'hb99b4092;
  int                n_fail = 0, check_count = 0, n_c3 = 0, c;

  always #25 sys_clk = ~sys_clk;

  dwu_ctrl #(.DEPTH(D)) u_dwu_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .ch_wdata(ch_wdata),
    .ch0_write(stb[0]), .ch1_write(stb[1]), .update_strobe(stb[2]),
    .clear_strobe(stb[3]), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .update_mode(mode), .waveform_enable(wave),
    .cyclic_enable(cyc), .channel_enable(chen), .dual_update_enable(dual),
    .request_half_full(half), .stop_at_buffer_end(stop),
    .retransmit_to_counter_source(rtx), .trigger_receive_select(rsel),
    .counter_select(csel), .timer_request_clear(stb[4]),
    .output_complete_clear(stb[5]), .external_update_trigger_n(pin_n[0]),
    .counter_out_n(pin_n[4:1]), .cycle_count_end(cend),
    .analog_output_zero_pin(out0), .analog_output_one_pin(out1),
    .counter3_source(c3src), .data_request(dreq),
    .timer_request_flag(treq), .output_complete_flag(done),
    .buffer_stopped(stopped), .fifo_level(level));

  dwu_host_model u_dwu_host_model (
    .sys_clk(sys_clk), .in_ready(in_ready), .in_data(in_data),
    .in_valid(in_valid));

  // buffer-end pulses seen on the counter 3 source line
  always @(posedge sys_clk) if (c3src === 1'b1) n_c3 <= n_c3 + 1;

  // expected request level for a fifo level and request setting
  function automatic logic exp_req(input int lvl, input logic h);
    return h ? (lvl < D / 2) : (lvl < D);
  endfunction : exp_req

  task automatic complete_run();
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk_code(input logic [DATA_W-1:0] got,
                          input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_code

  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  // one-cycle strobes with data, then settle
  task automatic pulse(input logic [5:0] m, input logic [DATA_W-1:0] v);
    stb      <= m;
    ch_wdata <= v;
    @(posedge sys_clk) stb <= '0;
    repeat (3) @(posedge sys_clk);
  endtask : pulse

  // active-low trigger pulse on one pin, long enough for the filter
  task automatic trig(input int b);
    pin_n[b] <= 1'b0;
    repeat (4) @(posedge sys_clk);
    pin_n[b] <= 1'b1;
    repeat (10) @(posedge sys_clk);
  endtask : trig

  // bounded wait for a fifo level; running out ends the run
  task automatic wait_level(input int n);
    int k;
    for (k = 0; k < 200; k++) begin
      @(posedge sys_clk);
      if (level === n[3:0]) break;
    end
    chk_code({12'h000, level}, n[15:0]);
    if (k == 200) complete_run();
  endtask : wait_level

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_code(out0, CODE_RST);
    chk_flag(in_ready, 1'b1);
    // register path under each update method
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      e = $random(seed);
      mode <= UPD_IMMEDIATE;
      pulse(6'h01, d);
      chk_code(out0, d);
      pulse(6'h02, e);
      chk_code(out1, e);
      mode <= UPD_STROBE;
      pulse(6'h01, ~d);
      chk_code(out0, d);
      pulse(6'h04, '0);
      chk_code(out0, ~d);
      mode <= dwu_mode_e'(2'b11);
      pulse(6'h02, ~e);
      pulse(6'h04, '0);
      chk_code(out1, e);
      mode <= UPD_TIMER;
      pulse(6'h01, d);
      trig(0);
      chk_code(out0, d);
      chk_code(out1, ~e);
    end
    // fifo filled until refused, then drained by timer pulses
    u_dwu_host_model.slow = 1'b1;
    mode <= UPD_TIMER;
    wave <= 1'b1;
    pulse(6'h08, '0);
    for (int i = 0; i < 10; i++) begin
      w[i] = $random(seed);
      u_dwu_host_model.push(w[i]);
    end
    wait_level(D);
    repeat (10) @(posedge sys_clk);
    chk_flag(in_ready, 1'b0);
    chk_flag(dreq, exp_req(D, 1'b0));
    for (int i = 0; i < 4; i++) begin
      trig(0);
      chk_code((i % 2) ? out1 : out0, w[i]);
    end
    chk_flag(treq, 1'b1);
    chk_flag(done, 1'b1);
    pulse(6'h30, '0);
    chk_flag(treq, 1'b0);
    chk_flag(done, 1'b0);
    c = $unsigned($random(seed)) % 4;
    dual <= 1'b1;
    rsel <= 1'b1;
    csel <= c[1:0];
    trig(c + 1);
    chk_code(out0, w[4]);
    chk_code(out1, w[5]);
    chen <= 2'b01;
    trig(c + 1);
    chk_code(out0, w[6]);
    chk_code(out1, w[5]);
    wait_level(3);
    half <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_flag(dreq, exp_req(3, 1'b1));
    cend <= 1'b1;
    repeat (4) @(posedge sys_clk);
    trig(c + 1);
    chk_code(out0, w[6]);
    cend <= 1'b0;
    pulse(6'h08, '0);
    wait_level(0);
    chk_flag(done, 1'b0);
    trig(c + 1);
    chk_code(out0, w[6]);
    // fifo-resident buffer replayed, then stopped at its end
    dual <= 1'b0;
    cyc  <= 1'b1;
    rtx  <= 1'b1;
    u_dwu_host_model.slow = 1'b0;
    for (int i = 0; i < 3; i++) u_dwu_host_model.push(w[i]);
    wait_level(3);
    for (int i = 0; i < 7; i++) begin
      if (i == 4) stop <= 1'b1;
      trig(c + 1);
      chk_code(out0, w[i > 5 ? 2 : i % 3]);
      if (i == 3) chk_code(n_c3[15:0], 16'h0001);
    end
    chk_flag(stopped, 1'b1);
    wait_level(3);
    complete_run();
  end
endmodule : tb_dwu_ctrl
